// file: verilog/icc_defs.svh
// icc_defs.svh: geometry, address fields, region map and reset values of the cache
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH
// ----------------------------------------------------------------
// geometry: 4 ways x 64 sets x 32-byte lines = 8 kbyte
// ----------------------------------------------------------------
`define ICC_WAYS 4
`define ICC_SETS 64
`define ICC_LINE_WORDS 8
`define ICC_LINE_BEATS 4
`define ICC_TAG_W 21
// ----------------------------------------------------------------
// address field positions (byte address)
// ----------------------------------------------------------------
`define ICC_WORD_LSB 2
`define ICC_BEAT_LSB 3
`define ICC_IDX_LSB 5
`define ICC_TAG_LSB 11
// ----------------------------------------------------------------
// cacheable regions and reset values
// ----------------------------------------------------------------
`define ICC_NVM_BASE 32'h6000_0000
`define ICC_NVM_SIZE 32'h0008_0000
`define ICC_DDR_BASE 32'ha000_0000
`define ICC_DDR_SIZE 32'h4000_0000
`define ICC_AGE_RESET 8'he4
`endif

// file: verilog/icc_pkg.sv
// icc_pkg: types shared by the instruction cache controller
`default_nettype none
`include "icc_defs.svh"
package icc_pkg;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } icc_req_type;
  typedef struct packed {
    logic ready;
    logic [31:0] data;
  } icc_rsp_type;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } icc_mreq_type;
  typedef struct packed {
    logic valid;
    logic [63:0] data;
  } icc_mrsp_type;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {icc_st_idle, icc_st_fill, icc_st_bypass} icc_fsm_type;
  typedef logic [`ICC_WAYS-1:0][1:0] icc_age_type;
  typedef struct packed {
    icc_fsm_type fsm;
    logic bus;
    logic [5:0] set;
    logic [1:0] way;
    logic [`ICC_TAG_W-1:0] tag;
    logic [1:0] beat;
    logic [1:0] crit;
    logic wsel;
    logic [2:0] left;
    logic [1:0] deliver;
    logic [31:0] word;
    logic [`ICC_SETS-1:0][`ICC_WAYS-1:0] valid;
    logic [`ICC_SETS-1:0][`ICC_WAYS-1:0][`ICC_TAG_W-1:0] tags;
    logic [`ICC_SETS-1:0] [`ICC_WAYS-1:0][1:0] ages;
    logic [`ICC_SETS-1:0][`ICC_WAYS-1:0][`ICC_LINE_WORDS-1:0][31:0] data;
  } icc_state_type;
endpackage
`default_nettype wire

// file: verilog/icc_cache.sv
// icc_cache: shared instruction cache controller for the two processor code buses
//
// Behaviour
// - The cache holds 8 kbyte arranged as four ways per set with set-associative lookup.
// - A hit answers the requesting bus in the same cycle, with no wait state.
// - The instruction and data code buses are both served from the one shared array.
// - A cacheable miss fills a whole line unless all ways are locked; the victim is the first invalid way, else the least recently used one.
// - In locked mode the locked ways keep their code and are never chosen as victims.
// - With the cache disabled every fetch goes straight to backing memory.
// - Fetches to the DDR region and to the nonvolatile memory region are cacheable.
`timescale 1ns/100ps
`default_nettype none
`include "icc_defs.svh"
module icc_cache (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic cache_en_i,
  input wire logic lock_en_i,
  input wire logic [`ICC_WAYS-1:0] lock_way_i,
  // instruction code bus
  input wire icc_pkg::icc_req_type ibus_req_i,
  output icc_pkg::icc_rsp_type ibus_rsp_o,
  // data code bus
  input wire icc_pkg::icc_req_type dbus_req_i,
  output icc_pkg::icc_rsp_type dbus_rsp_o,
  // backing memory read path
  output icc_pkg::icc_mreq_type mem_req_o,
  input wire icc_pkg::icc_mrsp_type mem_rsp_i
);
  import icc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic cacheable(input logic [31:0] a);
    cacheable = ((a >= `ICC_NVM_BASE) && ((a - `ICC_NVM_BASE) < `ICC_NVM_SIZE)) ||
                ((a >= `ICC_DDR_BASE) && ((a - `ICC_DDR_BASE) < `ICC_DDR_SIZE));
  endfunction

  // most recent way becomes age 0, younger ones age by one
  function automatic icc_age_type touch(input icc_age_type a, input logic [1:0] w);
    icc_age_type r;
    r = a;
    for (int k = 0; k < `ICC_WAYS; k++) begin
      if (a[k] < a[w]) begin
        r[k] = a[k] + 2'h1;
      end
    end
    r[w] = 2'h0;
    return r;
  endfunction

  // {found, way}: first invalid unlocked way, else the oldest unlocked way
  function automatic logic [2:0] victim(input logic [`ICC_WAYS-1:0] v, input icc_age_type a,
                                        input logic [`ICC_WAYS-1:0] lk);
    logic f;
    logic inv;
    logic [1:0] sel;
    f = 1'b0;
    inv = 1'b0;
    sel = 2'h0;
    for (int w = 0; w < `ICC_WAYS; w++) begin
      if (!lk[w]) begin
        if (!v[w] && !inv) begin
          f = 1'b1;
          inv = 1'b1;
          sel = 2'(w);
        end else if (!inv && (!f || a[w] > a[sel])) begin
          f = 1'b1;
          sel = 2'(w);
        end
      end
    end
    return {f, sel};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  icc_state_type st;
  icc_state_type next_st;
  icc_req_type req [2];
  icc_rsp_type rsp [2];
  logic [1:0] hit;
  logic [1:0][1:0] hway;
  logic [1:0] pend;
  logic [`ICC_WAYS-1:0] lk;
  logic [2:0] vic;
  logic sel_b;
  logic [5:0] idx;
  logic cab;

  assign req[0] = ibus_req_i;
  assign req[1] = dbus_req_i;
  assign ibus_rsp_o = rsp[0];
  assign dbus_rsp_o = rsp[1];
  // locked ways only count while locked mode is on
  assign lk = lock_en_i ? lock_way_i : '0;

  always_comb begin
    next_st = st;
    next_st.deliver = 2'b00;
    mem_req_o = '0;
    hit = 2'b00;
    hway = '0;
    pend = 2'b00;
    // both buses look up the same array in parallel
    for (int b = 0; b < 2; b++) begin
      idx = req[b].addr[`ICC_TAG_LSB-1:`ICC_IDX_LSB];
      for (int w = 0; w < `ICC_WAYS; w++) begin
        if (cache_en_i && cacheable(req[b].addr) && st.valid[idx][w] &&
            st.tags[idx][w] == req[b].addr[31:`ICC_TAG_LSB]) begin
          hit[b] = 1'b1;
          hway[b] = 2'(w);
        end
      end
      hit[b] = hit[b] && req[b].valid;
      rsp[b].ready = hit[b] || (req[b].valid && st.deliver[b]);
      rsp[b].data = hit[b] ?
                    st.data[idx][hway[b]][req[b].addr[`ICC_IDX_LSB-1:`ICC_WORD_LSB]] : st.word;
      if (hit[b]) begin
        next_st.ages[idx] = touch(next_st.ages[idx], hway[b]);
      end
      pend[b] = req[b].valid && !hit[b] && !st.deliver[b];
    end
    // instruction bus wins when both miss together
    sel_b = !pend[0];
    idx = req[sel_b].addr[`ICC_TAG_LSB-1:`ICC_IDX_LSB];
    cab = cache_en_i && cacheable(req[sel_b].addr);
    vic = victim(st.valid[idx], st.ages[idx], lk);
    unique case (st.fsm)
      icc_st_idle: begin
        if (pend != 2'b00) begin
          next_st.bus = sel_b;
          next_st.set = idx;
          next_st.tag = req[sel_b].addr[31:`ICC_TAG_LSB];
          next_st.beat = req[sel_b].addr[`ICC_IDX_LSB-1:`ICC_BEAT_LSB];
          next_st.crit = req[sel_b].addr[`ICC_IDX_LSB-1:`ICC_BEAT_LSB];
          next_st.wsel = req[sel_b].addr[`ICC_WORD_LSB];
          next_st.left = 3'(`ICC_LINE_BEATS);
          next_st.way = vic[1:0];
          // all ways locked: the miss is served without allocating
          if (cab && vic[2]) begin
            next_st.fsm = icc_st_fill;
            next_st.valid[idx][vic[1:0]] = 1'b0;
          end else begin
            next_st.fsm = icc_st_bypass;
          end
        end
      end
      icc_st_fill, icc_st_bypass: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.addr = {st.tag, st.set, st.beat, 3'h0};
        if (mem_rsp_i.valid) begin
          if (st.beat == st.crit) begin
            next_st.word = st.wsel ? mem_rsp_i.data[63:32] : mem_rsp_i.data[31:0];
            next_st.deliver[st.bus] = 1'b1;
          end
          if (st.fsm == icc_st_bypass) begin
            next_st.fsm = icc_st_idle;
          end else begin
            next_st.data[st.set][st.way][{st.beat, 1'b0}] = mem_rsp_i.data[31:0];
            next_st.data[st.set][st.way][{st.beat, 1'b1}] = mem_rsp_i.data[63:32];
            // beats wrap round the line, critical beat first
            next_st.beat = st.beat + 2'h1;
            next_st.left = st.left - 3'h1;
            if (st.left == 3'h1) begin
              next_st.valid[st.set][st.way] = 1'b1;
              next_st.tags[st.set][st.way] = st.tag;
              next_st.ages[st.set] = touch(next_st.ages[st.set], st.way);
              next_st.fsm = icc_st_idle;
            end
          end
        end
      end
      default: next_st.fsm = icc_st_idle;
    endcase
  end

  // ages start as a permutation so the replacement order is always total
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.ages <= {`ICC_SETS{`ICC_AGE_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  hit_zero_wait_a: assert property (hit[0] |-> ibus_rsp_o.ready)
    else $error("instruction hit not answered at once");
  shared_array_a: assert property ((hit[0] && hit[1] &&
    ibus_req_i.addr == dbus_req_i.addr) |-> ibus_rsp_o.data == dbus_rsp_o.data)
    else $error("buses disagree on one shared line");
  fill_length_a: assert property ((st.fsm == icc_st_idle &&
    next_st.fsm == icc_st_fill) |=> (st.left == 3'h4 && st.fsm == icc_st_fill))
    else $error("fill did not start with a full line");
  fill_done_a: assert property ((st.fsm == icc_st_fill && mem_rsp_i.valid &&
    st.left == 3'h1) |=> (st.fsm == icc_st_idle && st.valid[$past(st.set)][$past(st.way)]))
    else $error("line not valid after last beat");
  lru_victim_a: assert property ((st.fsm == icc_st_idle &&
    next_st.fsm == icc_st_fill && !lock_en_i && (&st.valid[idx])) |->
    st.ages[idx][vic[1:0]] == 2'h3)
    else $error("victim is not the oldest way");
  locked_keep_a: assert property ((st.fsm == icc_st_idle &&
    next_st.fsm == icc_st_fill) |-> !lk[vic[1:0]])
    else $error("locked way chosen for eviction");
  off_bypass_a: assert property ((!cache_en_i && st.fsm == icc_st_idle &&
    pend != 2'b00) |=> st.fsm == icc_st_bypass)
    else $error("disabled cache allocated a line");
  region_a: assert property (st.fsm == icc_st_fill |-> cacheable(mem_req_o.addr))
    else $error("fill outside cacheable regions");
  beat_align_a: assert property (mem_req_o.valid |-> mem_req_o.addr[2:0] == 3'h0)
    else $error("backing read not 64-bit aligned");
  crit_word_a: assert property ((st.fsm != icc_st_idle && mem_rsp_i.valid &&
    st.beat == st.crit && !st.bus && ibus_req_i.valid) |=> ibus_rsp_o.ready)
    else $error("critical word not delivered next cycle");
endmodule
`default_nettype wire

// file: dv/icc_mem_model.sv
// icc_mem_model: behavioural backing memory that answers line fills and bypass reads
`timescale 1ns/100ps
`default_nettype none
module icc_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bench control
  input wire logic [3:0] dly_i,
  input wire logic [31:0] gen_i,
  // memory port
  input wire icc_pkg::icc_mreq_type mem_req_i,
  output icc_pkg::icc_mrsp_type mem_rsp_o,
  output logic [15:0] beats_o
);
  import icc_pkg::*;
  logic [3:0] cnt;
  // a whole 64-bit beat per answer; gen_i lets the bench tell stale copies from fresh ones
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 4'h0;
      mem_rsp_o <= '0;
      beats_o <= 16'h0;
    end else begin
      mem_rsp_o.valid <= 1'b0;
      // data outside a beat toggles so it never passes for a held value
      mem_rsp_o.data <= ~mem_rsp_o.data;
      if (mem_req_i.valid && mem_rsp_o.valid) begin
        beats_o <= beats_o + 16'h1;
      end
      if (mem_req_i.valid && !mem_rsp_o.valid) begin
        if (cnt >= dly_i) begin
          mem_rsp_o.valid <= 1'b1;
          mem_rsp_o.data <= {(mem_req_i.addr + 32'h4) ^ gen_i, mem_req_i.addr ^ gen_i};
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_icc_cache.sv
// tb_icc_cache: self-checking bench for the shared instruction cache controller
`timescale 1ns/100ps
`default_nettype none
module tb_icc_cache;
  import icc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cache_en = 1'b1;
  logic lock_en = 1'b0;
  logic [3:0] lock_way = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [31:0] gen = 32'h0;
  icc_req_type ireq = '0;
  icc_req_type dreq = '0;
  icc_rsp_type irsp, drsp;
  icc_mreq_type mreq;
  icc_mrsp_type mrsp;
  logic [15:0] beats;
  int num_errors = 0;
  int n_checks = 0;
  localparam logic [31:0] NVM = 32'h6000_0000;
  localparam logic [31:0] SETA = 32'h6000_00a0;
  always #25 clk_i = ~clk_i;
  icc_cache uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cache_en_i(cache_en), .lock_en_i(lock_en),
    .lock_way_i(lock_way), .ibus_req_i(ireq), .ibus_rsp_o(irsp), .dbus_req_i(dreq),
    .dbus_rsp_o(drsp), .mem_req_o(mreq), .mem_rsp_i(mrsp));
  icc_mem_model mdl (.clk_i(clk_i), .rst_b_i(rst_b_i), .dly_i(dly), .gen_i(gen),
    .mem_req_i(mreq), .mem_rsp_o(mrsp), .beats_o(beats));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // entered at a falling edge; nb is the number of beats the fetch should cost
  task fetch(input bit d, input logic [31:0] a, input int nb);
    logic [15:0] b0;
    int waits;
    int idle;
    logic [31:0] dat;
    b0 = beats;
    waits = 0;
    idle = 0;
    if (d) dreq = '{1'b1, a};
    else ireq = '{1'b1, a};
    #24;
    while ((d ? drsp.ready : irsp.ready) !== 1'b1 && waits < 200) begin
      #50;
      waits++;
    end
    dat = d ? drsp.data : irsp.data;
    if (nb > 0) check(beats - b0, 1);
    @(negedge clk_i);
    ireq.valid = 1'b0;
    dreq.valid = 1'b0;
    // let the rest of the line land before counting beats
    for (int i = 0; i < 200 && idle < 3; i++) begin
      @(negedge clk_i);
      idle = (mreq.valid === 1'b0) ? idle + 1 : 0;
    end
    check(dat, a ^ gen);
    check(beats - b0, nb);
    check(waits == 0, nb == 0);
    // a limit that ran out is a hang, never a pass
    check(waits < 200, 1);
    check(idle == 3, 1);
  endtask
  // both buses present at once: one shared line answers both in the same cycle
  task t_both;
    ireq = '{1'b1, NVM + 32'h08};
    dreq = '{1'b1, NVM + 32'h08};
    #24;
    check(irsp.ready, 1'b1);
    check(drsp.ready, 1'b1);
    check(irsp.data, NVM + 32'h08);
    check(drsp.data, NVM + 32'h08);
    @(negedge clk_i);
    ireq.valid = 1'b0;
    dreq.valid = 1'b0;
    @(negedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_miss_hit;
    dly = 4'h2;
    fetch(0, NVM + 32'h1c, 4);
    fetch(0, NVM + 32'h04, 0);
    fetch(1, NVM + 32'h10, 0);
  endtask
  task t_ddr_dbus;
    dly = 4'h0;
    fetch(1, 32'ha000_0108, 4);
    fetch(0, 32'ha000_0100, 0);
    fetch(0, 32'h2000_0040, 1);
    fetch(0, 32'h2000_0040, 1);
  endtask
  task t_lru;
    for (int k = 0; k < 4; k++) fetch(0, SETA + k * 32'h800, 4);
    for (int k = 0; k < 4; k++) fetch(1, SETA + k * 32'h800, 0);
    fetch(0, SETA, 0);
    fetch(0, SETA + 32'h2000, 4);
    fetch(0, SETA, 0);
    fetch(0, SETA + 32'h800, 4);
  endtask
  task t_lock;
    lock_en = 1'b1;
    lock_way = 4'hf;
    fetch(0, SETA + 32'h3000, 1);
    fetch(0, SETA + 32'h3000, 1);
    fetch(1, SETA, 0);
    // only way 3 locked: it holds the oldest line, so the next oldest goes instead
    lock_way = 4'h8;
    fetch(0, SETA + 32'h3000, 4);
    fetch(1, SETA + 32'h1800, 0);
    fetch(0, SETA + 32'h2000, 4);
    lock_en = 1'b0;
  endtask
  task t_disable;
    cache_en = 1'b0;
    gen = 32'h5a5a_0000;
    fetch(0, SETA, 1);
    fetch(1, NVM + 32'h04, 1);
    cache_en = 1'b1;
    gen = 32'h0;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    @(negedge clk_i);
    t_miss_hit();
    t_ddr_dbus();
    t_lru();
    t_lock();
    t_disable();
    t_both();
    test_done();
  end
  // fetch gives up on a hung handshake after 200 waits; this cuts off the whole run well past the expected run
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
